// file: vis_pkg.sv
// =====================================================================
// shared constants and types of the vectored request sequencer
// =====================================================================
package vis_pkg;

  // =====================================================================
  // widths and sizes
  // =====================================================================
  localparam int NUM_SRC     = 32;
  localparam int SRC_W       = 5;
  localparam int PRIO_W      = 3;
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W     = 4;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;
  localparam int ENTRY_W     = SRC_W + PRIO_W;

  // =====================================================================
  // register byte offsets
  // =====================================================================
  localparam logic [ADDR_W-1:0] OFS_MODE_BASE       = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_VECT_BASE       = 12'h080;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_VECTOR   = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_FAST_VECTOR     = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_CUR_SOURCE      = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_PENDING         = 12'h10c;
  localparam logic [ADDR_W-1:0] OFS_ENABLE          = 12'h110;
  localparam logic [ADDR_W-1:0] OFS_CORE_STATUS     = 12'h114;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CMD      = 12'h120;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_CMD     = 12'h124;
  localparam logic [ADDR_W-1:0] OFS_END_OF_SERVICE  = 12'h130;
  localparam logic [ADDR_W-1:0] OFS_SPURIOUS_VECTOR = 12'h134;
  // array decode: bits above the word index select mode or vector bank
  localparam int BANK_LSB = 7;
  localparam int IDX_LSB  = 2;

  // =====================================================================
  // mode register fields and reset values
  // =====================================================================
  localparam int PRIO_LSB      = 0;
  localparam int TYPE_EDGE_BIT = 5;
  localparam int TYPE_POL_BIT  = 6;
  localparam logic [NUM_SRC-1:0] EXT_SRC_MASK = 32'h1000_0001;
  localparam logic [SRC_W-1:0]   FAST_SRC     = 5'h00;
  localparam logic [DATA_W-1:0]  WORD_RESET   = 32'h0000_0000;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL   = 4'h8;

  // =====================================================================
  // types
  // =====================================================================
  typedef logic [PRIO_W-1:0]  vis_prio_type;
  typedef logic [SRC_W-1:0]   vis_src_type;
  typedef logic [DATA_W-1:0]  vis_word_type;
  typedef logic [ENTRY_W-1:0] vis_entry_type;

endpackage

// file: vis_prio_pick.sv
`timescale 1ns/1ns
// =====================================================================
// highest-priority pending normal source, lowest number on a tie
// =====================================================================
module vis_prio_pick
  import vis_pkg::*;
(
  // candidates
  input  wire logic [NUM_SRC-1:0]        i_active,
  input  wire logic [NUM_SRC*PRIO_W-1:0] i_prio,
  // winner
  output logic                           o_valid,
  output vis_src_type                    o_src,
  output vis_prio_type                   o_prio
);

  // scan from the top down; >= lets a lower number take a tie
  always_comb begin
    o_valid = 1'b0;
    o_src   = FAST_SRC;
    o_prio  = '0;
    for (int k = NUM_SRC - 1; k >= 1; k--) begin
      if (i_active[k] && (!o_valid || i_prio[k*PRIO_W +: PRIO_W] >= o_prio)) begin
        o_valid = 1'b1;
        o_src   = SRC_W'(k);
        o_prio  = i_prio[k*PRIO_W +: PRIO_W];
      end
    end
  end

endmodule

// file: vis_level_stack.sv
`timescale 1ns/1ns
// =====================================================================
// last-in first-out store of interrupted source and level
// =====================================================================
module vis_level_stack
  import vis_pkg::*;
(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // commands
  input  wire logic          i_push,
  input  wire logic          i_pop,
  input  vis_entry_type      i_data,
  // state
  output vis_entry_type      o_top,
  output logic [DEPTH_W-1:0] o_depth
);

  vis_entry_type      mem [STACK_DEPTH];
  logic [DEPTH_W-1:0] depth;

  // one entry per level, so legal nesting never reaches the guard
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      depth <= '0;
    end else if (i_push && depth != DEPTH_FULL) begin
      mem[depth[DEPTH_W-2:0]] <= i_data;
      depth                  <= depth + 1'b1;
    end else if (i_pop && depth != '0) begin
      depth <= depth - 1'b1;
    end
  end

  assign o_depth = depth;
  assign o_top   = (depth == '0) ? '0 : mem[3'(depth - 1'b1)];

endmodule

// file: vis_sequencer.sv
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
// What this block does
// - vector read makes highest-priority pending source current, level its priority
// - vector read drops the normal request line
// - vector read clears pending state of an edge-triggered current source
// - vector read pushes level on stack and returns the source's handler address
// - in service, a strictly higher pending priority raises the line again
// - end-of-service write outside normal spurious handling pops the stack, restoring the previous level
// - after the pop, a pending priority above restored level raises the line
// - fast vector read clears an edge-triggered source 0
// - fast line drops on fast vector read only when edge-triggered
// - a vanished level-triggered source drops its request line
// - normal vector read with the line idle returns the spurious vector
// - fast vector read with the fast line idle returns the spurious vector
// - after a spurious read the line stays idle until end-of-service
// - current-source status reads zero during normal-line spurious handling
// - each normal source carries a level 0 to 7, 7 most urgent
// - ties in level go to the lowest source number
// - only source 0 drives the fast line, all others the normal line
module vis_sequencer
  import vis_pkg::*;
(
  // clock and reset
  input  wire logic               I_CLK_SYS,
  input  wire logic               I_RST,
  // apb slave
  input  wire logic               I_PSEL,
  input  wire logic               I_PENABLE,
  input  wire logic               I_PWRITE,
  input  wire logic [ADDR_W-1:0]  I_PADDR,
  input  wire logic [DATA_W-1:0]  I_PWDATA,
  output logic      [DATA_W-1:0]  O_PRDATA,
  output logic                    O_PREADY,
  output logic                    O_PSLVERR,
  // interrupt sources, source 0 is the fast input
  input  wire logic [NUM_SRC-1:0] I_SRC,
  // core request lines, active low
  output logic                    O_CORE_REQUEST_LINE_N,
  output logic                    O_CORE_FAST_REQUEST_LINE_N
);

  // =====================================================================
  // storage
  // =====================================================================
  logic [NUM_SRC*PRIO_W-1:0] mode_prio;
  logic [NUM_SRC-1:0]        mode_edge;
  logic [NUM_SRC-1:0]        mode_pol;
  vis_word_type              vect [NUM_SRC];
  vis_word_type              spu_vect;
  logic [NUM_SRC-1:0]        enable;
  logic [NUM_SRC-1:0]        src_q;
  logic [NUM_SRC-1:0]        pend_edge;
  logic                      spur_irq;
  logic                      spur_fiq;

  // =====================================================================
  // bus decode
  // =====================================================================
  logic                 rd_setup;
  logic                 wr_done;
  logic [SRC_W-1:0]     idx;
  logic                 in_mode;
  logic                 in_vect;
  logic                 take_irq;
  logic                 spur_ivr;
  logic                 read_fvr;
  logic                 eoi_wr;
  vis_word_type         next_rdata;
  logic                 next_err;

  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign wr_done  = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  assign idx      = I_PADDR[IDX_LSB +: SRC_W];
  assign in_mode  = I_PADDR[ADDR_W-1:BANK_LSB] == OFS_MODE_BASE[ADDR_W-1:BANK_LSB];
  assign in_vect  = I_PADDR[ADDR_W-1:BANK_LSB] == OFS_VECT_BASE[ADDR_W-1:BANK_LSB];
  assign eoi_wr   = wr_done && I_PADDR == OFS_END_OF_SERVICE;

  // =====================================================================
  // source conditioning, one lane per source
  // =====================================================================
  logic [NUM_SRC-1:0] norm;
  logic [NUM_SRC-1:0] edge_seen;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] clr_edge;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_lane
      // internal sources have no polarity bit, so it never inverts them
      assign norm[g]      = I_SRC[g] ^ (EXT_SRC_MASK[g] && !mode_pol[g]);
      assign edge_seen[g] = norm[g] && !src_q[g];
      // a level source is pending only while it stands; edge ones latch
      assign pending[g]   = mode_edge[g] ? pend_edge[g] : norm[g];
    end
  endgenerate

  // previous sample for edge detection
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      src_q <= '0;
    end else begin
      src_q <= norm;
    end
  end

  // edge latches; a new edge in the clearing cycle wins over the clear
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      pend_edge <= '0;
    end else begin
      pend_edge <= (pend_edge & ~clr_edge) | (edge_seen & mode_edge);
    end
  end

  // =====================================================================
  // priority selection and nesting stack
  // =====================================================================
  logic               best_valid;
  vis_src_type        best_src;
  vis_prio_type       best_prio;
  vis_entry_type      top;
  logic [DEPTH_W-1:0] depth;
  vis_prio_type       cur_prio;
  vis_src_type        cur_src;
  logic               irq_want;
  logic               fiq_want;

  // source 0 is masked out here: it only ever feeds the fast line
  vis_prio_pick u_pick (
    .i_active (pending & enable),
    .i_prio   (mode_prio),
    .o_valid  (best_valid),
    .o_src    (best_src),
    .o_prio   (best_prio)
  );

  vis_level_stack u_stack (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_RST),
    .i_push  (take_irq),
    .i_pop   (eoi_wr && !spur_irq),
    .i_data  ({best_src, best_prio}),
    .o_top   (top),
    .o_depth (depth)
  );

  assign cur_src  = top[ENTRY_W-1:PRIO_W];
  assign cur_prio = top[PRIO_W-1:0];

  // strictly above the current level, or anything when nothing is in service
  assign irq_want = best_valid && (depth == '0 || best_prio > cur_prio) && !spur_irq;
  assign fiq_want = pending[FAST_SRC] && enable[FAST_SRC] && !spur_fiq;

  // =====================================================================
  // vector read side effects, applied at the setup edge of the read
  // =====================================================================
  assign take_irq = rd_setup && I_PADDR == OFS_NORMAL_VECTOR
                    && !O_CORE_REQUEST_LINE_N && best_valid;
  assign spur_ivr = rd_setup && I_PADDR == OFS_NORMAL_VECTOR && !take_irq;
  assign read_fvr = rd_setup && I_PADDR == OFS_FAST_VECTOR;

  // edge sources lose their pending state when they are taken
  always_comb begin
    clr_edge = '0;
    if (take_irq) begin
      clr_edge[best_src] = 1'b1;
    end
    if (read_fvr && !O_CORE_FAST_REQUEST_LINE_N) begin
      clr_edge[FAST_SRC] = 1'b1;
    end
  end

  // spurious holds; the line stays idle until end-of-service arrives
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      spur_irq <= 1'b0;
      spur_fiq <= 1'b0;
    end else begin
      if (spur_ivr) begin
        spur_irq <= 1'b1;
      end else if (eoi_wr) begin
        spur_irq <= 1'b0;
      end
      if (read_fvr && O_CORE_FAST_REQUEST_LINE_N) begin
        spur_fiq <= 1'b1;
      end else if (eoi_wr) begin
        spur_fiq <= 1'b0;
      end
    end
  end

  // request lines: registered, so the vector read drops them one edge after its setup edge
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_CORE_REQUEST_LINE_N      <= 1'b1;
      O_CORE_FAST_REQUEST_LINE_N <= 1'b1;
    end else begin
      O_CORE_REQUEST_LINE_N      <= !irq_want;
      O_CORE_FAST_REQUEST_LINE_N <= !fiq_want;
    end
  end

  // =====================================================================
  // register writes, taken at the access edge
  // =====================================================================
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mode_prio <= '0;
      mode_edge <= '0;
      mode_pol  <= '0;
      enable    <= '0;
      spu_vect  <= WORD_RESET;
    end else if (wr_done) begin
      if (in_mode) begin
        mode_prio[idx*PRIO_W +: PRIO_W] <= I_PWDATA[PRIO_LSB +: PRIO_W];
        mode_edge[idx]                  <= I_PWDATA[TYPE_EDGE_BIT];
        mode_pol[idx]                   <= I_PWDATA[TYPE_POL_BIT] && EXT_SRC_MASK[idx];
      end
      if (I_PADDR == OFS_ENABLE_CMD) begin
        enable <= enable | I_PWDATA;
      end
      if (I_PADDR == OFS_DISABLE_CMD) begin
        enable <= enable & ~I_PWDATA;
      end
      if (I_PADDR == OFS_SPURIOUS_VECTOR) begin
        spu_vect <= I_PWDATA;
      end
    end
  end

  // handler addresses; no reset needed since software loads them first
  always_ff @(posedge I_CLK_SYS) begin
    if (wr_done && in_vect) begin
      vect[idx] <= I_PWDATA;
    end
  end

  // =====================================================================
  // read mux and bus answer
  // =====================================================================
  always_comb begin
    next_rdata = WORD_RESET;
    next_err   = 1'b0;
    if (in_mode) begin
      next_rdata[PRIO_LSB +: PRIO_W] = mode_prio[idx*PRIO_W +: PRIO_W];
      next_rdata[TYPE_EDGE_BIT]      = mode_edge[idx];
      next_rdata[TYPE_POL_BIT]       = mode_pol[idx];
    end else if (in_vect) begin
      next_rdata = vect[idx];
    end else begin
      unique case (I_PADDR)
        OFS_NORMAL_VECTOR:   next_rdata = take_irq ? vect[best_src] : spu_vect;
        OFS_FAST_VECTOR:     next_rdata = O_CORE_FAST_REQUEST_LINE_N ? spu_vect
                                          : vect[FAST_SRC];
        OFS_CUR_SOURCE:      next_rdata = (spur_irq || depth == '0) ? WORD_RESET
                                          : DATA_W'(cur_src);
        OFS_PENDING:         next_rdata = pending;
        OFS_ENABLE:          next_rdata = enable;
        OFS_CORE_STATUS:     next_rdata = DATA_W'({!O_CORE_REQUEST_LINE_N, !O_CORE_FAST_REQUEST_LINE_N});
        OFS_SPURIOUS_VECTOR: next_rdata = spu_vect;
        OFS_ENABLE_CMD, OFS_DISABLE_CMD, OFS_END_OF_SERVICE: next_rdata = WORD_RESET;
        default:             next_err   = 1'b1;
      endcase
    end
  end

  // one access cycle: ready comes up the cycle after setup
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= WORD_RESET;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && next_err;
      if (rd_setup) begin
        O_PRDATA <= next_rdata;
      end
    end
  end

  // =====================================================================
  // checks
  // =====================================================================
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  stack_push_a: assert property (take_irq && depth != DEPTH_FULL |=> depth == $past(depth) + 1'b1)
    else $error("vector read did not push the stack");

  eoi_pop_a: assert property (eoi_wr && !spur_irq && depth != '0 |=> depth == $past(depth) - 1'b1)
    else $error("end-of-service did not pop the stack");

  raise_level_a: assert property (!O_CORE_REQUEST_LINE_N && $past(depth) != '0
                                  |-> $past(best_prio) > $past(cur_prio))
    else $error("line raised without a strictly higher level");

  ivr_drop_a: assert property (take_irq ##1 !(best_valid && best_prio > cur_prio)
                               |=> O_CORE_REQUEST_LINE_N)
    else $error("line still asserted after the vector read");

  edge_clear_a: assert property (take_irq && mode_edge[best_src] && !edge_seen[best_src]
                                 |=> !pend_edge[$past(best_src)])
    else $error("edge source not cleared by vector read");

  spur_vector_a: assert property (spur_ivr |=> O_PRDATA == $past(spu_vect))
    else $error("idle normal vector read did not return the spurious vector");

  fast_spur_a: assert property (read_fvr && O_CORE_FAST_REQUEST_LINE_N |=> O_PRDATA == $past(spu_vect))
    else $error("idle fast vector read did not return the spurious vector");

  spur_hold_a: assert property (spur_irq && $past(spur_irq) |-> O_CORE_REQUEST_LINE_N)
    else $error("normal line raised before end-of-service after spurious read");

  spur_status_a: assert property (rd_setup && I_PADDR == OFS_CUR_SOURCE && spur_irq
                                  |=> O_PRDATA == WORD_RESET)
    else $error("current source not zero during spurious handling");

  // the source may legally vanish after the read, so it must still stand
  fast_level_a: assert property (read_fvr && !mode_edge[FAST_SRC] && !O_CORE_FAST_REQUEST_LINE_N ##1
                                 norm[FAST_SRC] && enable[FAST_SRC] |=> !O_CORE_FAST_REQUEST_LINE_N)
    else $error("fast line dropped for a level source");

  fast_edge_a: assert property (read_fvr && mode_edge[FAST_SRC] && !O_CORE_FAST_REQUEST_LINE_N
                                && !edge_seen[FAST_SRC] |=> ##1 O_CORE_FAST_REQUEST_LINE_N)
    else $error("fast line kept after reading an edge source");

  vanish_drop_a: assert property (!O_CORE_REQUEST_LINE_N && !best_valid |=> O_CORE_REQUEST_LINE_N)
    else $error("normal line kept after its source vanished");

  pop_raise_a: assert property (eoi_wr && !spur_irq ##1 depth == '0 && best_valid && !spur_irq
                                |=> !O_CORE_REQUEST_LINE_N)
    else $error("line not raised for a pending source after the pop");

  take_level_a: assert property (take_irq && depth != DEPTH_FULL
                                 |=> cur_prio == $past(best_prio) && cur_src == $past(best_src))
    else $error("vector read did not make the winner current");

  fast_only_a: assert property (!O_CORE_FAST_REQUEST_LINE_N
                                |-> $past(pending[FAST_SRC] && enable[FAST_SRC]))
    else $error("fast line raised without the fast source");

endmodule

// file: vis_core_model.sv
`timescale 1ns/1ns
// =====================================================================
// core and handler model, master of the register bus
// =====================================================================
module vis_core_model
  import vis_pkg::*;
(
  // clock
  input  wire logic                i_clk,
  // apb master
  output logic                     o_psel,
  output logic                     o_penable,
  output logic                     o_pwrite,
  output logic      [ADDR_W-1:0]   o_paddr,
  output logic      [DATA_W-1:0]   o_pwdata,
  input  wire logic [DATA_W-1:0]   i_prdata,
  input  wire logic                i_pready,
  input  wire logic                i_pslverr
);
  int   n_to = 0;    // transfers that never saw ready
  logic err;
  logic mask = 1'b0; // normal mask bit of the core status word
  // bus idle from time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = '0;
    o_pwdata = '0;
  end
  // one transfer; held until ready is seen at an edge, for at most 16 edges, then counted as a timeout
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input vis_word_type wd, output vis_word_type q);
    int k;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= wd;
    @(posedge i_clk);
    o_penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge i_clk);
      if (i_pready === 1'b1) break;
    end
    if (k == 16) n_to++;
    q = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;   // released bus shows no stale address
    o_pwdata <= ~wd;
  endtask
  // vector fetch at the exception entry loads the program counter
  task automatic take(input logic f, output vis_word_type v);
    bus(1'b0, f ? OFS_FAST_VECTOR : OFS_NORMAL_VECTOR, '0, v);
  endtask
  // leave the handler masked, closing with end of service
  task automatic leave();
    vis_word_type q;
    mask = 1'b1;
    bus(1'b1, OFS_END_OF_SERVICE, '0, q);
    mask = 1'b0;
  endtask
endmodule

// file: test_vis_sequencer.sv
`timescale 1ns/1ns
// =====================================================================
// bench of the vectored request sequencer
// =====================================================================
module test_vis_sequencer;
  import vis_pkg::*;
  logic               clk, rst, psel, pen, pwr, prdy, perr, rq_n, fq_n;
  logic [ADDR_W-1:0]  pa;
  logic [DATA_W-1:0]  pwd, prd;
  logic [NUM_SRC-1:0] src, s;
  vis_word_type       vec [NUM_SRC];
  vis_prio_type       lvl [NUM_SRC];
  vis_word_type       d, spur;
  int                 num_errors = 0;
  int                 n_tests = 0;
  int                 seed = 32'h2ca2;

  vis_sequencer i_vis_sequencer (
    .I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .I_SRC(src), .O_CORE_REQUEST_LINE_N(rq_n), .O_CORE_FAST_REQUEST_LINE_N(fq_n));
  vis_core_model i_vis_core_model (
    .i_clk(clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(pa),
    .o_pwdata(pwd), .i_prdata(prd), .i_pready(prdy), .i_pslverr(perr));

  // 250 mhz system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a bus transfer that never saw ready ends the run at once
  always @(posedge clk) begin
    if (i_vis_core_model.n_to != 0) begin
      num_errors += i_vis_core_model.n_to;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chb(input string nm, input logic seen, input logic exp); chk(nm, 32'(seen), 32'(exp)); endtask
  task automatic rd(input logic [ADDR_W-1:0] a); i_vis_core_model.bus(1'b0, a, '0, d); endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input vis_word_type v); i_vis_core_model.bus(1'b1, a, v, d); endtask
  // mode word: polarity high, edge flag, level
  task automatic mode(input int i, input vis_prio_type l, input logic e);
    lvl[i] = l;
    wr(OFS_MODE_BASE + 12'(4 * i), {25'h0, 1'b1, e, 2'b00, l});
  endtask
  // bounded wait for a request line; a hang ends the run
  task automatic waitl(input logic f, input logic v);
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if ((f ? fq_n : rq_n) === v) break;
    end
    if (k == 40) begin
      num_errors++;
      results();
    end
  endtask
  // expected winner: highest level, lowest number on a tie
  function automatic int pick(input logic [NUM_SRC-1:0] m);
    int w = 0;
    for (int i = 1; i < NUM_SRC; i++)
      if (m[i] && (w == 0 || lvl[i] > lvl[w])) w = i;
    return w;
  endfunction

  // main sequence
  initial begin
    rst = 1'b1;
    src = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chb("idle lines", rq_n & fq_n, 1'b1);
    rd(OFS_SPURIOUS_VECTOR);
    chk("spurious reset", d, 32'h0);
    spur = $random(seed);
    wr(OFS_SPURIOUS_VECTOR, spur);
    rd(12'h118);
    chb("unmapped", i_vis_core_model.err, 1'b1);
    for (int i = 0; i < NUM_SRC; i++) begin
      vec[i] = $random(seed);
      wr(OFS_VECT_BASE + 12'(4 * i), vec[i]);
      mode(i, 3'h0, 1'b0);
    end
    wr(OFS_ENABLE_CMD, '1);
    rd(OFS_ENABLE);
    chk("enable", d, '1);
    // random contests among normal sources
    repeat (8) begin
      for (int i = 1; i < NUM_SRC; i++) mode(i, 3'($random(seed)), 1'b0);
      s = $random(seed) | 32'h2;
      s[0] = 1'b0;
      src <= s;
      waitl(1'b0, 1'b0);
      i_vis_core_model.take(1'b0, d);
      chk("vector", d, vec[pick(s)]);
      rd(OFS_CUR_SOURCE);
      chk("current", d, 32'(pick(s)));
      chb("line after read", rq_n, 1'b1);
      src <= '0;
      i_vis_core_model.leave();
      rd(OFS_CUR_SOURCE);
      chk("popped", d, 32'h0);
    end
    // eight-deep nesting, one source per level
    for (int k = 0; k < 8; k++) mode(k + 1, 3'(k), 1'b0);
    s = '0;
    for (int k = 0; k < 8; k++) begin
      s[k + 1] = 1'b1;
      src <= s;
      waitl(1'b0, 1'b0);
      i_vis_core_model.take(1'b0, d);
      chk("nested", d, vec[k + 1]);
    end
    for (int k = 7; k >= 0; k--) begin
      s[k + 1] = 1'b0;
      src <= s;
      i_vis_core_model.leave();
      rd(OFS_CUR_SOURCE);
      chk("unwind", d, 32'(k));
      chb("unwind quiet", rq_n, 1'b1);
    end
    // lower level waits, then raises the line after the pop
    mode(1, 3'h5, 1'b0);
    mode(2, 3'h3, 1'b0);
    src <= 32'h2;
    waitl(1'b0, 1'b0);
    i_vis_core_model.take(1'b0, d);
    src <= 32'h6;
    repeat (4) @(posedge clk);
    chb("lower quiet", rq_n, 1'b1);
    src <= 32'h4;
    i_vis_core_model.leave();
    waitl(1'b0, 1'b0);
    i_vis_core_model.take(1'b0, d);
    chk("restored", d, vec[2]);
    src <= '0;
    i_vis_core_model.leave();
    // edge source cleared by the vector read
    mode(9, 3'h4, 1'b1);
    rd(OFS_MODE_BASE + 12'h024);
    chk("mode word", d, 32'h24);
    src <= 32'h200;
    waitl(1'b0, 1'b0);
    i_vis_core_model.take(1'b0, d);
    chk("edge vector", d, vec[9]);
    rd(OFS_PENDING);
    chb("edge pending", d[9], 1'b0);
    i_vis_core_model.leave();
    repeat (4) @(posedge clk);
    chb("edge idle", rq_n, 1'b1);
    src <= '0;
    // fast source, edge then level mode
    mode(0, 3'h0, 1'b1);
    src <= 32'h1;
    waitl(1'b1, 1'b0);
    chb("normal quiet", rq_n, 1'b1);
    i_vis_core_model.take(1'b1, d);
    chk("fast vector", d, vec[0]);
    waitl(1'b1, 1'b1);
    src <= '0;
    mode(0, 3'h0, 1'b0);
    src <= 32'h1;
    waitl(1'b1, 1'b0);
    i_vis_core_model.take(1'b1, d);
    chk("fast level vector", d, vec[0]);
    repeat (4) @(posedge clk);
    chb("fast held", fq_n, 1'b0);
    rd(OFS_CORE_STATUS);
    chk("core status", d, 32'h1);
    src <= '0;
    waitl(1'b1, 1'b1);
    // vanished source and spurious handling
    mode(3, 3'h2, 1'b0);
    src <= 32'h8;
    waitl(1'b0, 1'b0);
    src <= '0;
    waitl(1'b0, 1'b1);
    i_vis_core_model.take(1'b0, d);
    chk("spurious", d, spur);
    rd(OFS_CUR_SOURCE);
    chk("spurious status", d, 32'h0);
    src <= 32'h8;
    repeat (4) @(posedge clk);
    chb("held idle", rq_n, 1'b1);
    i_vis_core_model.leave();
    waitl(1'b0, 1'b0);
    i_vis_core_model.take(1'b0, d);
    chk("after spurious", d, vec[3]);
    src <= '0;
    i_vis_core_model.leave();
    i_vis_core_model.take(1'b1, d);
    chk("fast spurious", d, spur);
    i_vis_core_model.leave();
    // external source 28 active low: an idle input means pending
    lvl[28] = 3'h6;
    wr(OFS_MODE_BASE + 12'h070, 32'h0000_0006);
    waitl(1'b0, 1'b0);
    i_vis_core_model.take(1'b0, d);
    chk("active low vector", d, vec[28]);
    src <= 32'h1000_0000;
    i_vis_core_model.leave();
    rd(OFS_PENDING);
    chk("active low idle", d, 32'h0);
    num_errors += i_vis_core_model.n_to;
    results();
  end
endmodule
